/* File: twbf_pkg.sv */
// What this block does
// - SDA stable while SCL high, except conditions.
// - START/STOP are SDA edges during SCL high.
// - Bus busy from START until STOP.
// - Repeated START keeps bus busy until STOP.
// - Address packet: seven bits, direction, acknowledge.
// - Direction one means read, zero write.
// - Matching slave acknowledges address, busy slave releases.
// - After address NACK master stops or restarts.
// - Address byte travels most significant bit first.
// - Zero address is general call, write only.
// - General call with read bit is not answered.
// - Addresses 1111xxx are reserved, never our own.
// - Data packet: eight bits plus acknowledge bit.
// - Master makes clock and conditions; receiver acknowledges.
// - ACK drives SDA low, NACK leaves it released.
// - Receiver NACKs its final byte.
// - Data bytes travel most significant bit first.
// - Lines are only pulled low or released.
// - Power gate bit high keeps the interface disabled.
// - Master waits for SCL to rise; slaves stretch.
// - Master never sends START directly followed by STOP.
package twbf_pkg;
    localparam int          TWBF_CLK_HZ       = 100_000_000;
    localparam int          TWBF_SCL_HZ       = 100_000;
    localparam int          TWBF_HALF_CYC     = TWBF_CLK_HZ / (4 * TWBF_SCL_HZ);
    localparam int          TWBF_ADDR_W       = 7;
    localparam int          TWBF_BITS_PKT     = 9;
    localparam logic [6:0]  TWBF_GCALL_ADDR   = 7'h00;
    localparam logic [3:0]  TWBF_RSVD_UPPER   = 4'hF;
    localparam logic [7:0]  TWBF_DATA_RST     = 8'h00;

    typedef enum logic [1:0] {
        TWBF_CMD_NONE,
        TWBF_CMD_START,
        TWBF_CMD_BYTE,
        TWBF_CMD_STOP
    } twbf_cmd_t;
endpackage

/* File: twbf_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module twbf_sync
    import twbf_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;

    // Lines idle high, so reset to one avoids a false condition at release.
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_r <= 1'b1;
            q_o    <= 1'b1;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: twbf_core.sv */
`timescale 1ns/1ps
`default_nettype none
module twbf_core
    import twbf_pkg::*;
#(
    parameter int HALF_CYC = TWBF_HALF_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       serial_bus_power_gate_i,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_n_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    input  wire logic [6:0] own_addr_i,
    input  wire logic       gcall_en_i,
    input  wire logic       slave_ack_i,
    input  wire logic [7:0] slave_tx_data_i,
    input  wire logic       cmd_valid_i,
    input  wire twbf_cmd_t  cmd_i,
    input  wire logic [7:0] cmd_data_i,
    input  wire logic       cmd_ack_i,
    output logic            cmd_ready_o,
    output logic            bus_busy_o,
    output logic            start_o,
    output logic            stop_o,
    output logic            addr_valid_o,
    output logic            addressed_o,
    output logic            gcall_o,
    output logic            dir_read_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    output logic            rx_ack_o,
    output logic            mst_done_o,
    output logic [7:0]      mst_rx_data_o,
    output logic            mst_ack_o
);
    typedef enum logic [1:0] {
        TWBF_S_IDLE,
        TWBF_S_ADDR,
        TWBF_S_DATA,
        TWBF_S_SKIP
    } twbf_sst_t;

    typedef enum logic [2:0] {
        TWBF_M_IDLE,
        TWBF_M_START,
        TWBF_M_LOW,
        TWBF_M_HIGH,
        TWBF_M_STOP,
        TWBF_M_HOLD
    } twbf_mst_t;

    function automatic logic twbf_reserved(input logic [6:0] a);
        return a[6:3] == TWBF_RSVD_UPPER;
    endfunction

    logic       scl_s;
    logic       sda_s;
    logic       scl_q_r;
    logic       sda_q_r;
    logic       en;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       busy_r;
    twbf_sst_t  sst_r;
    logic [3:0] sbit_r;
    logic [7:0] sshift_r;
    logic [7:0] stx_r;
    logic       stx_mode_r;
    logic       sdrive_r;
    logic       addr_pkt_r;
    twbf_mst_t  mst_r;
    logic [15:0] mcnt_r;
    logic [3:0] mbit_r;
    logic [8:0] mshift_r;
    logic [7:0] mrx_r;
    logic       msda_r;
    logic       mscl_r;
    logic       mowner_r;
    logic       mhad_pkt_r;
    logic       cmd_start_r;
    logic       sack_slot;
    logic       mtime;

    twbf_sync u_scl_sync (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(scl_i), .q_o(scl_s));
    twbf_sync u_sda_sync (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(sda_i), .q_o(sda_s));

    assign en        = !serial_bus_power_gate_i;
    assign scl_rise  = scl_s && !scl_q_r;
    assign scl_fall  = !scl_s && scl_q_r;
    assign start_det = en && scl_s && scl_q_r && sda_q_r && !sda_s;
    assign stop_det  = en && scl_s && scl_q_r && !sda_q_r && sda_s;
    assign sack_slot = sbit_r == 4'(TWBF_BITS_PKT - 1);
    assign mtime     = mcnt_r == 16'(HALF_CYC - 1);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    // A repeated START leaves the flag set; only STOP, reset or the power gate clears it.
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !en) begin
            busy_r <= 1'b0;
        end else if (start_det) begin
            busy_r <= 1'b1;
        end else if (stop_det) begin
            busy_r <= 1'b0;
        end
    end

    // Slave side: bits sampled on SCL rise, driven after SCL fall.
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !en) begin
            sst_r        <= TWBF_S_IDLE;
            sbit_r       <= 4'h0;
            sshift_r     <= TWBF_DATA_RST;
            stx_r        <= TWBF_DATA_RST;
            stx_mode_r   <= 1'b0;
            sdrive_r     <= 1'b0;
            addr_pkt_r   <= 1'b0;
            addr_valid_o <= 1'b0;
            addressed_o  <= 1'b0;
            gcall_o      <= 1'b0;
            dir_read_o   <= 1'b0;
            rx_data_o    <= TWBF_DATA_RST;
            rx_valid_o   <= 1'b0;
            rx_ack_o     <= 1'b0;
        end else begin
            addr_valid_o <= 1'b0;
            rx_valid_o   <= 1'b0;
            if (start_det) begin
                sst_r      <= TWBF_S_ADDR;
                sbit_r     <= 4'h0;
                sdrive_r   <= 1'b0;
                stx_mode_r <= 1'b0;
                addr_pkt_r <= 1'b0;
                addressed_o <= 1'b0;
                gcall_o    <= 1'b0;
            end else if (stop_det) begin
                sst_r       <= TWBF_S_IDLE;
                sdrive_r    <= 1'b0;
                addressed_o <= 1'b0;
                gcall_o     <= 1'b0;
            end else if (sst_r != TWBF_S_IDLE && scl_rise) begin
                if (!sack_slot) begin
                    sshift_r <= {sshift_r[6:0], sda_s};
                    sbit_r   <= sbit_r + 4'h1;
                end else begin
                    sbit_r <= 4'h0;
                    // Marks a finished address packet, so the first fall after START stays in ADDR.
                    addr_pkt_r <= sst_r == TWBF_S_ADDR;
                    if (sst_r == TWBF_S_DATA && stx_mode_r) begin
                        rx_ack_o <= !sda_s;
                        if (sda_s) begin
                            sst_r <= TWBF_S_SKIP;
                        end
                    end
                end
                if (sst_r == TWBF_S_ADDR && sbit_r == 4'(TWBF_ADDR_W)) begin
                    addr_valid_o <= 1'b1;
                    dir_read_o   <= sda_s;
                    // Own address in the reserved range is never matched.
                    if (sshift_r[6:0] == own_addr_i && !twbf_reserved(own_addr_i)) begin
                        addressed_o <= slave_ack_i;
                    end else if (sshift_r[6:0] == TWBF_GCALL_ADDR && !sda_s) begin
                        addressed_o <= gcall_en_i;
                        gcall_o     <= gcall_en_i;
                    end
                end
                if (sst_r == TWBF_S_DATA && !stx_mode_r && sbit_r == 4'h7) begin
                    rx_data_o  <= {sshift_r[6:0], sda_s};
                    rx_valid_o <= 1'b1;
                end
            end else if (sst_r != TWBF_S_IDLE && scl_fall) begin
                if (sst_r == TWBF_S_ADDR && sbit_r == 4'h8) begin
                    sdrive_r <= addressed_o;
                    if (!addressed_o) begin
                        sst_r <= TWBF_S_SKIP;
                    end
                end else if (sbit_r == 4'h0 && sst_r != TWBF_S_SKIP &&
                             (sst_r != TWBF_S_ADDR || addr_pkt_r)) begin
                    addr_pkt_r <= 1'b0;
                    if (sst_r == TWBF_S_ADDR) begin
                        sst_r      <= TWBF_S_DATA;
                        stx_mode_r <= dir_read_o;
                        stx_r      <= slave_tx_data_i;
                    end else if (stx_mode_r) begin
                        stx_r <= slave_tx_data_i;
                    end
                    sdrive_r <= dir_read_o && (sst_r == TWBF_S_ADDR || stx_mode_r) &&
                                !slave_tx_data_i[7];
                end else if (sst_r == TWBF_S_DATA && stx_mode_r && sbit_r < 4'h8) begin
                    sdrive_r <= !stx_r[3'(7 - sbit_r)];
                end else if (sst_r == TWBF_S_DATA && !stx_mode_r && sbit_r == 4'h8) begin
                    sdrive_r <= slave_ack_i;
                end else begin
                    sdrive_r <= 1'b0;
                end
            end
        end
    end

    // Master side: one command at a time, held in the bit engine.
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !en) begin
            mst_r         <= TWBF_M_IDLE;
            mcnt_r        <= 16'h0;
            mbit_r        <= 4'h0;
            mshift_r      <= 9'h1FF;
            mrx_r         <= TWBF_DATA_RST;
            msda_r        <= 1'b1;
            mscl_r        <= 1'b1;
            mowner_r      <= 1'b0;
            mhad_pkt_r    <= 1'b0;
            cmd_start_r   <= 1'b0;
            mst_done_o    <= 1'b0;
            mst_rx_data_o <= TWBF_DATA_RST;
            mst_ack_o     <= 1'b0;
        end else begin
            mst_done_o <= 1'b0;
            mcnt_r     <= mtime ? 16'h0 : mcnt_r + 16'h1;
            unique case (mst_r)
                TWBF_M_IDLE: begin
                    mcnt_r <= 16'h0;
                    if (cmd_valid_i && cmd_i == TWBF_CMD_START && (!busy_r || mowner_r)) begin
                        mst_r  <= TWBF_M_START;
                        msda_r <= 1'b1;
                        mscl_r <= 1'b1;
                    end else if (cmd_valid_i && cmd_i == TWBF_CMD_BYTE && mowner_r) begin
                        mst_r    <= TWBF_M_LOW;
                        mshift_r <= {cmd_data_i, !cmd_ack_i};
                        mbit_r   <= 4'h0;
                    end else if (cmd_valid_i && cmd_i == TWBF_CMD_STOP && mowner_r && mhad_pkt_r) begin
                        mst_r  <= TWBF_M_STOP;
                        msda_r <= 1'b0;
                    end else if (cmd_valid_i && cmd_i != TWBF_CMD_NONE) begin
                        mst_done_o <= 1'b1;
                    end
                end
                TWBF_M_START: begin
                    if (mtime && scl_s) begin
                        msda_r <= 1'b0;
                        mst_r  <= TWBF_M_HOLD;
                        cmd_start_r <= 1'b1;
                    end
                end
                TWBF_M_HOLD: begin
                    if (mtime) begin
                        mscl_r      <= 1'b0;
                        mowner_r    <= 1'b1;
                        mhad_pkt_r  <= 1'b0;
                        cmd_start_r <= 1'b0;
                        mst_done_o  <= 1'b1;
                        mst_r       <= TWBF_M_IDLE;
                    end
                end
                TWBF_M_LOW: begin
                    mscl_r <= 1'b0;
                    // Data moves two cycles into the low phase, never together with an SCL edge.
                    if (mcnt_r == 16'h1) begin
                        msda_r <= mshift_r[8];
                    end
                    if (mtime) begin
                        mscl_r <= 1'b1;
                        mst_r  <= TWBF_M_HIGH;
                    end
                end
                TWBF_M_HIGH: begin
                    if (!scl_s) begin
                        mcnt_r <= 16'h0;
                    end else if (mtime) begin
                        mscl_r   <= 1'b0;
                        mshift_r <= {mshift_r[7:0], 1'b1};
                        mbit_r   <= mbit_r + 4'h1;
                        if (mbit_r < 4'h8) begin
                            mrx_r <= {mrx_r[6:0], sda_s};
                            mst_r <= TWBF_M_LOW;
                        end else begin
                            mst_ack_o     <= !sda_s;
                            mst_rx_data_o <= mrx_r;
                            mhad_pkt_r    <= 1'b1;
                            mst_done_o    <= 1'b1;
                            mst_r         <= TWBF_M_IDLE;
                        end
                    end
                end
                TWBF_M_STOP: begin
                    mscl_r <= 1'b1;
                    if (mtime && scl_s) begin
                        msda_r     <= 1'b1;
                        mowner_r   <= 1'b0;
                        mst_done_o <= 1'b1;
                        mst_r      <= TWBF_M_IDLE;
                    end
                end
                default: mst_r <= TWBF_M_IDLE;
            endcase
        end
    end

    // Outputs only ever pull low; the enable is low when driving.
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe_n_o  = mscl_r;
    assign sda_oe_n_o  = msda_r && !sdrive_r;
    assign cmd_ready_o = en && mst_r == TWBF_M_IDLE;
    assign bus_busy_o  = busy_r;
    assign start_o     = start_det;
    assign stop_o      = stop_det;
endmodule
`default_nettype wire

/* File: twbf_props.sv */
`timescale 1ns/1ps
`default_nettype none
module twbf_props
    import twbf_pkg::*;
#(
    parameter int HALF_CYC = TWBF_HALF_CYC
) (
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       serial_bus_power_gate_i,
    input wire logic       scl_o,
    input wire logic       sda_o,
    input wire logic       scl_oe_n_o,
    input wire logic       sda_oe_n_o,
    input wire logic [6:0] own_addr_i,
    input wire logic       gcall_en_i,
    input wire logic       bus_busy_o,
    input wire logic       start_o,
    input wire logic       stop_o,
    input wire logic       addr_valid_o,
    input wire logic       addressed_o,
    input wire logic       gcall_o,
    input wire logic       dir_read_o,
    input wire logic       mst_done_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    gate_idle_a: assert property (
        $past(serial_bus_power_gate_i) && serial_bus_power_gate_i
        |-> scl_oe_n_o && sda_oe_n_o && !bus_busy_o) else $error("Active while gated.");
    drive_low_a: assert property (!scl_o && !sda_o) else $error("Line driven high.");
    start_busy_a: assert property (start_o |=> bus_busy_o) else $error("Start left bus free.");
    stop_free_a: assert property (
        stop_o && !start_o |=> !bus_busy_o) else $error("Stop left bus busy.");
    busy_hold_a: assert property (
        bus_busy_o && !stop_o && !serial_bus_power_gate_i |=> bus_busy_o)
        else $error("Busy dropped without stop.");
    busy_cause_a: assert property (
        $rose(bus_busy_o) |-> $past(start_o)) else $error("Busy without start.");
    cond_apart_a: assert property (!(start_o && stop_o)) else $error("Start and stop at once.");
    rsvd_own_a: assert property (
        $rose(addressed_o) && !gcall_o |-> own_addr_i[6:3] != TWBF_RSVD_UPPER)
        else $error("Reserved address matched.");
    gcall_wr_a: assert property (
        $rose(gcall_o) |-> gcall_en_i && !dir_read_o) else $error("Bad general call.");
    cover property (start_o);
    cover property (addr_valid_o && addressed_o);
    cover property (mst_done_o && bus_busy_o);
endmodule
bind twbf_core twbf_props #(.HALF_CYC(HALF_CYC)) u_props (.*);
`default_nettype wire

/* File: twbf_far.sv */
`timescale 1ns/1ps
`default_nettype none
module twbf_far #(
    parameter logic [6:0] SLV_ADDR = 7'h33
) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output var logic  scl_rel_o,
    output var logic  sda_rel_o
);
    localparam int T = 40;
    logic       m_sda_r = 1'b1;
    logic       s_ack_r = 1'b0;
    logic       sel_r   = 1'b0;
    logic [7:0] sh_r    = 8'h00;
    logic [7:0] got_r   = 8'h00;
    int         cnt_r   = 0;
    initial scl_rel_o = 1'b1;
    // Lines are only ever pulled low or let go; the pull-up does the rest.
    assign sda_rel_o = m_sda_r & ~s_ack_r;
    always @(negedge sda_i) if (scl_i) begin
        cnt_r = 0;
        sel_r = 1'b0;
    end
    always @(posedge scl_i) begin
        if (cnt_r < 8) sh_r = {sh_r[6:0], sda_i};
        cnt_r = cnt_r + 1;
    end
    always @(negedge scl_i) begin
        if (cnt_r == 8 && !sel_r && sh_r == {SLV_ADDR, 1'b0}) sel_r = 1'b1;
        s_ack_r = (cnt_r == 8) && sel_r;
        if (cnt_r == 8) got_r = sh_r;
        if (cnt_r == 9) cnt_r = 0;
    end
    task automatic m_start();
        m_sda_r = 1'b1;
        #T scl_rel_o = 1'b1;
        #(2*T) m_sda_r = 1'b0;
        #(2*T) scl_rel_o = 1'b0;
        #T;
    endtask
    // Data only moves while the clock is low; a stretched clock is waited out.
    task automatic m_bit(input logic b, output logic seen);
        m_sda_r = b;
        #T scl_rel_o = 1'b1;
        for (int i = 0; i < 100 && !scl_i; i++) #10;
        #T seen = sda_i;
        #T scl_rel_o = 1'b0;
        #T;
    endtask
    task automatic m_byte(input logic [7:0] b, input logic ab, output logic ack,
                          output logic [7:0] rd);
        for (int i = 7; i >= 0; i--) m_bit(b[i], rd[i]);
        m_bit(ab, ack);
    endtask
    task automatic m_stop();
        m_sda_r = 1'b0;
        #T scl_rel_o = 1'b1;
        #(2*T) m_sda_r = 1'b1;
        #(2*T);
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import twbf_pkg::*;
;
    logic       clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       serial_bus_power_gate_i = 1'b0;
    logic [6:0] own_addr_i = 7'h2A;
    logic       gcall_en_i = 1'b0;
    logic       slave_ack_i = 1'b1;
    logic [7:0] slave_tx_data_i = 8'h96;
    logic       cmd_valid_i = 1'b0;
    twbf_cmd_t  cmd_i = TWBF_CMD_NONE;
    logic [7:0] cmd_data_i = 8'h00;
    logic       cmd_ack_i = 1'b0;
    logic       scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, cmd_ready_o, bus_busy_o, start_o, stop_o;
    logic       addr_valid_o, addressed_o, gcall_o, dir_read_o, rx_valid_o, rx_ack_o;
    logic       mst_done_o, mst_ack_o, scl_rel, sda_rel, saw_stop = 1'b0;
    logic [7:0] rx_data_o, mst_rx_data_o, rd;
    logic       a;
    int         fail_count = 0, comparisons = 0;
    wire logic  scl_i = scl_oe_n_o & scl_rel;
    wire logic  sda_i = sda_oe_n_o & sda_rel;
    twbf_core #(.HALF_CYC(4)) dut (.*);
    twbf_far far (.scl_i(scl_i), .sda_i(sda_i), .scl_rel_o(scl_rel), .sda_rel_o(sda_rel));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (stop_o === 1'b1) saw_stop <= 1'b1;
    task automatic final_report();
        if (fail_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits are bounded so a stuck master cannot hang the run.
    task automatic cmd(input twbf_cmd_t c, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_i <= c;
        cmd_data_i <= d;
        do @(posedge clk_i); while (cmd_ready_o !== 1'b1 && ++n < 50);
        cmd_valid_i <= 1'b0;
        while (mst_done_o !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) begin
            check(1'b0, 1'b1);
            final_report();
        end
    endtask
    task automatic t_slave();
        saw_stop = 1'b0;
        far.m_start();
        check(bus_busy_o, 1'b1);
        far.m_byte({7'h2A, 1'b0}, 1'b1, a, rd);
        check(a, 1'b0);
        check({addressed_o, dir_read_o}, 2'b10);
        far.m_byte(8'hA5, 1'b1, a, rd);
        check(a, 1'b0);
        check(rx_data_o, 8'hA5);
        far.m_start();
        check(bus_busy_o, 1'b1);
        far.m_byte({7'h2A, 1'b1}, 1'b1, a, rd);
        check(dir_read_o, 1'b1);
        far.m_byte(8'hFF, 1'b1, a, rd);
        check(rd, 8'h96);
        far.m_stop();
        repeat (4) @(posedge clk_i);
        check({bus_busy_o, saw_stop}, 2'b01);
    endtask
    task automatic t_addr();
        logic [17:0] tb_row [4] = '{{7'h2A, 1'b0, 8'hAA, 2'b10}, {7'h2A, 1'b1, 8'h00, 2'b01},
                                    {7'h2A, 1'b1, 8'h01, 2'b10}, {7'h78, 1'b0, 8'hF0, 2'b10}};
        foreach (tb_row[i]) begin
            @(posedge clk_i);
            own_addr_i <= tb_row[i][17:11];
            gcall_en_i <= tb_row[i][10];
            far.m_start();
            far.m_byte(tb_row[i][9:2], 1'b1, a, rd);
            check(a, tb_row[i][1]);
            check(gcall_o, tb_row[i][0]);
            far.m_stop();
        end
    endtask
    task automatic t_master();
        saw_stop = 1'b0;
        cmd(TWBF_CMD_START, 8'h00);
        check(bus_busy_o, 1'b1);
        cmd(TWBF_CMD_STOP, 8'h00);
        check(bus_busy_o, 1'b1);
        cmd(TWBF_CMD_BYTE, {7'h33, 1'b0});
        check({far.got_r, mst_ack_o}, {8'h66, 1'b1});
        cmd(TWBF_CMD_BYTE, 8'hC3);
        check(far.got_r, 8'hC3);
        cmd(TWBF_CMD_START, 8'h00);
        cmd(TWBF_CMD_BYTE, {7'h11, 1'b0});
        check(mst_ack_o, 1'b0);
        cmd(TWBF_CMD_STOP, 8'h00);
        repeat (4) @(posedge clk_i);
        check({bus_busy_o, saw_stop}, 2'b01);
    endtask
    task automatic t_gate();
        @(posedge clk_i);
        serial_bus_power_gate_i <= 1'b1;
        own_addr_i <= 7'h2A;
        far.m_start();
        check(bus_busy_o, 1'b0);
        far.m_byte({7'h2A, 1'b0}, 1'b1, a, rd);
        check(a, 1'b1);
        far.m_stop();
        serial_bus_power_gate_i <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_slave();
        t_addr();
        t_master();
        t_gate();
        final_report();
    end
endmodule
`default_nettype wire
